/* File: logic/curr_mon_pkg.sv */
// Purpose: shared constants and carriers for the output current threshold monitor
// Assumes: 10 MHz system clock, one current sample per clock
// Notes: times are held in units of 10 ms (setting value 1 = 0.01 s)
package curr_mon_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [7:0] PCT_RATED = 8'h64;
    localparam logic [7:0] OC_LEVEL_RST = 8'h96;
    localparam logic [7:0] ZC_LEVEL_RST = 8'h05;
    localparam logic [7:0] PCT_MAX = 8'hdc;
    localparam logic [13:0] TIME_10S = 14'h03e8;
    localparam logic [13:0] TIME_1S = 14'h0064;
    localparam logic [13:0] OC_DELAY_RST = 14'h0000;
    localparam logic [13:0] OC_RETAIN_RST = 14'h000a;
    localparam logic [13:0] ZC_TIME_RST = 14'h0032;
    localparam logic [13:0] ZC_MIN_ON = 14'h000a;
    localparam logic [13:0] RETAIN_FOREVER = 14'h270f;
    localparam logic [7:0] FC_OC_POS = 8'h0c;
    localparam logic [7:0] FC_OC_NEG = 8'h70;
    localparam logic [7:0] FC_ZC_POS = 8'h0d;
    localparam logic [7:0] FC_ZC_NEG = 8'h71;

    typedef struct packed {
        logic [7:0] oc_level;
        logic [13:0] oc_delay;
        logic [7:0] zc_level;
        logic [13:0] zc_time;
        logic [13:0] oc_retention;
        logic oc_action_trip;
    } settings_t;

    typedef struct packed {
        logic oc_flag;
        logic zc_flag;
    } flags_t;
endpackage

/* File: logic/tick_gen.sv */
// Purpose: one-cycle pulse every 10 ms time base unit
// Assumes: free-running system clock
// Notes: all qualification and hold timers count these ticks
`timescale 1ns/1ps
module tick_gen
    import curr_mon_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Time base
    output logic tick_o
);
    logic [23:0] count;
    wire logic wrap = (count == 24'(CYCLES - 1));

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 24'h000000;
        end else begin
            count <= wrap ? 24'h000000 : count + 24'h000001;
        end
    end

    assign tick_o = wrap;
endmodule

/* File: logic/term_map.sv */
// Purpose: drive one open-collector output terminal from its function code
// Assumes: codes other than the four handled leave the terminal off
// Notes: output enable high means the transistor conducts
`timescale 1ns/1ps
module term_map
    import curr_mon_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Selection and flags
    input wire logic [7:0] code_i,
    input wire flags_t flags_i,
    // Terminal
    output logic term_o,
    output logic term_oe_o
);
    wire logic next_on = (code_i == FC_OC_POS) ? flags_i.oc_flag :
                         (code_i == FC_OC_NEG) ? !flags_i.oc_flag :
                         (code_i == FC_ZC_POS) ? flags_i.zc_flag :
                         (code_i == FC_ZC_NEG) ? !flags_i.zc_flag :
                         1'b0;
    logic on;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            on <= 1'b0;
        end else begin
            on <= next_on;
        end
    end

    // Open collector: pulled low when on, released when off
    assign term_o = 1'b0;
    assign term_oe_o = on;
endmodule

/* File: logic/curr_threshold_mon.sv */
// Purpose: overcurrent and zero-current detection with timed flags and trip
// Assumes: current sample in percent of rated current, same clock domain
// Notes: timer settings in 10 ms units; out-of-range settings are clamped
// Behaviour
// - While running, assert overcurrent flag after current exceeds level beyond delay.
// - Overcurrent delay programmable 0 to 10 s, default 0 s.
// - Levels are percent of rated current; 100 equals rated.
// - Overcurrent flag held for retention time, 0 to 10 s, default 0.1 s.
// - Retention 9999 holds overcurrent flag until next start command.
// - Action 1 trips and raises fault when overcurrent flag asserts.
// - Action 0 continues normal operation while overcurrent flag asserted.
// - After trip, flag held retention time, or until reset at 9999.
// - Action changed to trip while flag asserted does not trip until deassert.
// - Terminal code 12 carries overcurrent flag positive, 112 negative.
// - While running, assert zero-current flag after current below level beyond time.
// - Zero-current time programmable 0 to 1 s, default 0.5 s.
// - Zero-current flag stays asserted at least 0.1 s once set.
// - Terminal code 13 carries zero-current flag positive, 113 negative.
// - Zero-current level zero disables zero-current detection.
// - Both flags respond within about 0.1 s.
// - Detection stays active during motor auto-tuning.
`timescale 1ns/1ps
module curr_threshold_mon
    import curr_mon_pkg::*;
#(
    parameter int unsigned NUM_TERMS = 7,
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Drive status
    input wire logic running_i,
    input wire logic start_cmd_i,
    input wire logic autotune_i,
    input wire logic [7:0] current_pct_i,
    // Settings
    input wire logic [7:0] overcurrent_level_setting_i,
    input wire logic [13:0] overcurrent_delay_setting_i,
    input wire logic [7:0] zero_current_level_setting_i,
    input wire logic [13:0] zero_current_time_setting_i,
    input wire logic [13:0] overcurrent_retention_setting_i,
    input wire logic overcurrent_action_selection_i,
    input wire logic [NUM_TERMS*8-1:0] terminal_function_codes_i,
    // Status
    output logic overcurrent_detect_flag_o,
    output logic zero_current_flag_o,
    output logic overcurrent_trip_fault_o,
    // Terminals
    output logic [NUM_TERMS-1:0] term_o,
    output logic [NUM_TERMS-1:0] term_oe_o
);
    ////////////////////////////////////////////////////////////////////////
    logic tick;
    settings_t cfg;
    flags_t flags;

    tick_gen #(.CYCLES(TICK_CYC)) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // Clamp settings to their documented ranges
    assign cfg.oc_level = (overcurrent_level_setting_i > PCT_MAX) ? PCT_MAX
                        : overcurrent_level_setting_i;
    assign cfg.zc_level = (zero_current_level_setting_i > PCT_MAX) ? PCT_MAX
                        : zero_current_level_setting_i;
    assign cfg.oc_delay = (overcurrent_delay_setting_i > TIME_10S) ? TIME_10S
                        : overcurrent_delay_setting_i;
    assign cfg.zc_time = (zero_current_time_setting_i > TIME_1S) ? TIME_1S
                       : zero_current_time_setting_i;
    assign cfg.oc_retention = (overcurrent_retention_setting_i == RETAIN_FOREVER) ? RETAIN_FOREVER
                            : (overcurrent_retention_setting_i > TIME_10S) ? TIME_10S
                            : overcurrent_retention_setting_i;
    assign cfg.oc_action_trip = overcurrent_action_selection_i;

    ////////////////////////////////////////////////////////////////////////
    // Detection is qualified by running or auto-tuning; auto-tuning does not mask it
    wire logic active = running_i || autotune_i;
    wire logic above = active && (current_pct_i > cfg.oc_level);
    wire logic zc_enabled = (cfg.zc_level != 8'h00);
    wire logic below = active && zc_enabled && (current_pct_i < cfg.zc_level);
    wire logic retain_forever = (cfg.oc_retention == RETAIN_FOREVER);

    ////////////////////////////////////////////////////////////////////////
    // Overcurrent qualification and hold
    logic [13:0] oc_qual;
    logic [13:0] oc_hold;
    logic oc_flag;
    logic oc_latched;
    logic trip;

    wire logic oc_qualified = above && (oc_qual >= cfg.oc_delay);
    wire logic oc_rise = oc_qualified && !oc_flag;
    wire logic hold_done = (oc_hold >= cfg.oc_retention);
    // The trip choice is sampled only at the rising edge of the flag
    wire logic trip_now = oc_rise && cfg.oc_action_trip;
    // A fault with 9999 waits for reset; a plain hold with 9999 waits for start
    wire logic oc_release = oc_flag && !oc_qualified && !oc_latched && hold_done
                          && !retain_forever;
    wire logic start_clear = oc_latched && !trip && start_cmd_i && !oc_qualified;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            oc_qual <= 14'h0000;
        end else if (!above) begin
            oc_qual <= 14'h0000;
        end else if (tick && oc_qual < cfg.oc_delay) begin
            oc_qual <= oc_qual + 14'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            oc_flag <= 1'b0;
            oc_latched <= 1'b0;
            oc_hold <= 14'h0000;
        end else begin
            if (oc_rise) begin
                oc_flag <= 1'b1;
                oc_latched <= retain_forever && !cfg.oc_action_trip;
            end else if (oc_release || start_clear) begin
                oc_flag <= 1'b0;
                oc_latched <= 1'b0;
            end
            // Hold time counts from the last qualified moment
            if (oc_qualified) begin
                oc_hold <= 14'h0000;
            end else if (oc_flag && tick && !hold_done) begin
                oc_hold <= oc_hold + 14'h0001;
            end
        end
    end

    // Trip fault persists until drive reset; action 0 never sets it
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            trip <= 1'b0;
        end else if (trip_now) begin
            trip <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Zero-current qualification and minimum on-time
    logic [13:0] zc_qual;
    logic [13:0] zc_min;
    logic zc_flag;

    wire logic zc_qualified = below && (zc_qual >= cfg.zc_time);
    wire logic zc_min_done = (zc_min >= ZC_MIN_ON);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            zc_qual <= 14'h0000;
        end else if (!below) begin
            zc_qual <= 14'h0000;
        end else if (tick && zc_qual < cfg.zc_time) begin
            zc_qual <= zc_qual + 14'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            zc_flag <= 1'b0;
            zc_min <= 14'h0000;
        end else if (zc_qualified && !zc_flag) begin
            zc_flag <= 1'b1;
            zc_min <= 14'h0000;
        end else if (zc_flag) begin
            if (tick && !zc_min_done) begin
                zc_min <= zc_min + 14'h0001;
            end
            if (zc_min_done && !zc_qualified) begin
                zc_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign flags.oc_flag = oc_flag;
    assign flags.zc_flag = zc_flag;
    assign overcurrent_detect_flag_o = oc_flag;
    assign zero_current_flag_o = zc_flag;
    assign overcurrent_trip_fault_o = trip;

    genvar t;
    generate
        for (t = 0; t < NUM_TERMS; t++) begin : g_term
            term_map u_term (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .code_i(terminal_function_codes_i[t*8 +: 8]),
                .flags_i(flags),
                .term_o(term_o[t]),
                .term_oe_o(term_oe_o[t])
            );
        end
    endgenerate
endmodule

/* File: testbench/curr_mon_chk.sv */
// Purpose: port-level checks for the current threshold monitor
// Assumes: one clock, terminals keep fixed function codes
// Notes: zero-current hold is counted in cycles, so a tick of jitter is allowed
`timescale 1ns/1ps
module curr_mon_chk
    import curr_mon_pkg::*;
#(
    parameter int unsigned NUM_TERMS = 7
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic running_i,
    input wire logic autotune_i,
    input wire logic [7:0] current_pct_i,
    input wire logic [7:0] overcurrent_level_setting_i,
    input wire logic [13:0] overcurrent_delay_setting_i,
    input wire logic [7:0] zero_current_level_setting_i,
    input wire logic overcurrent_action_selection_i,
    input wire logic [NUM_TERMS*8-1:0] terminal_function_codes_i,
    input wire logic overcurrent_detect_flag_o,
    input wire logic zero_current_flag_o,
    input wire logic overcurrent_trip_fault_o,
    input wire logic [NUM_TERMS-1:0] term_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    int unsigned zc_on;
    logic act;
    assign act = running_i || autotune_i;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) zc_on <= 0;
        else zc_on <= zero_current_flag_o ? zc_on + 1 : 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_oc_cond;
        act && current_pct_i > overcurrent_level_setting_i;
    endsequence
    sequence s_oc_now;
        s_oc_cond ##0 (overcurrent_delay_setting_i == 14'h0000 && !overcurrent_detect_flag_o);
    endsequence
    property p_oc_fast;
        s_oc_now |=> overcurrent_detect_flag_o;
    endproperty
    a_oc_fast: assert property (p_oc_fast) else $error("overcurrent flag late");
    property p_oc_cause;
        $rose(overcurrent_detect_flag_o) |->
            $past(act && current_pct_i > overcurrent_level_setting_i);
    endproperty
    a_oc_cause: assert property (p_oc_cause) else $error("overcurrent flag without cause");
    property p_trip_cause;
        $rose(overcurrent_trip_fault_o) |->
            $rose(overcurrent_detect_flag_o) && $past(overcurrent_action_selection_i);
    endproperty
    a_trip_cause: assert property (p_trip_cause)
        else $error("trip without flag rise");
    property p_late_trip;
        $past(overcurrent_detect_flag_o) |-> !$rose(overcurrent_trip_fault_o);
    endproperty
    a_late_trip: assert property (p_late_trip) else $error("trip while flag held");
    property p_fault_sticky;
        overcurrent_trip_fault_o |=> overcurrent_trip_fault_o;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("trip fault dropped");
    property p_zc_cause;
        $rose(zero_current_flag_o) |-> $past(act && zero_current_level_setting_i != 8'h00
            && current_pct_i < zero_current_level_setting_i);
    endproperty
    a_zc_cause: assert property (p_zc_cause)
        else $error("zero flag without cause");
    property p_zc_min;
        $fell(zero_current_flag_o) |-> zc_on >= 90;
    endproperty
    a_zc_min: assert property (p_zc_min) else $error("zero flag too short");
    property p_term_oc;
        !$past(rst_i) && terminal_function_codes_i[15:8] == FC_OC_NEG |->
            term_oe_o[1] == !$past(overcurrent_detect_flag_o);
    endproperty
    a_term_oc: assert property (p_term_oc) else $error("negative terminal wrong");
    property p_term_zc;
        !$past(rst_i) && terminal_function_codes_i[23:16] == FC_ZC_POS |->
            term_oe_o[2] == $past(zero_current_flag_o);
    endproperty
    a_term_zc: assert property (p_term_zc) else $error("zero terminal wrong");
endmodule
bind curr_threshold_mon curr_mon_chk #(.NUM_TERMS(NUM_TERMS)) u_curr_mon_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .running_i(running_i), .autotune_i(autotune_i),
    .current_pct_i(current_pct_i), .overcurrent_level_setting_i(overcurrent_level_setting_i),
    .overcurrent_delay_setting_i(overcurrent_delay_setting_i),
    .zero_current_level_setting_i(zero_current_level_setting_i),
    .overcurrent_action_selection_i(overcurrent_action_selection_i),
    .terminal_function_codes_i(terminal_function_codes_i),
    .overcurrent_detect_flag_o(overcurrent_detect_flag_o),
    .zero_current_flag_o(zero_current_flag_o),
    .overcurrent_trip_fault_o(overcurrent_trip_fault_o), .term_oe_o(term_oe_o));

/* File: testbench/ext_equip.sv */
// Purpose: equipment reading the open-collector terminals
// Assumes: a pull-up on every line at this end
// Notes: a released line reads high, so it reads OFF
`timescale 1ns/1ps
module ext_equip #(
    parameter int unsigned N = 7
) (
    // Terminals
    input wire logic [N-1:0] term_i,
    input wire logic [N-1:0] term_oe_i,
    // Seen state
    output logic [N-1:0] on_o
);
    logic [N-1:0] line_lvl;
    assign line_lvl = (term_oe_i & term_i) | ~term_oe_i;
    assign on_o = ~line_lvl;
endmodule

/* File: testbench/tb_top.sv */
// Purpose: random and corner tests of the current threshold monitor
// Assumes: tick shortened to 10 cycles
// Notes: flags are sampled on the falling edge
`timescale 1ns/1ps
module tb_top;
    import curr_mon_pkg::*;
    localparam int TK = 10;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic running_i = 1'b0;
    logic start_cmd_i = 1'b0;
    logic autotune_i = 1'b0;
    logic [7:0] cur = 8'h00;
    settings_t s;
    logic [55:0] codes = {16'h0000, 8'h2a, FC_ZC_NEG, FC_ZC_POS, FC_OC_NEG, FC_OC_POS};
    wire flags_t f;
    logic fault;
    logic [6:0] term, term_oe, seen_on;
    int n_fail = 0;
    int compares = 0;
    int seed = 32'hccfc4015;
    int cyc_cnt = 0;
    int n;
    curr_threshold_mon #(.NUM_TERMS(7), .TICK_CYC(TK)) u_curr_threshold_mon (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .running_i(running_i), .start_cmd_i(start_cmd_i),
        .autotune_i(autotune_i), .current_pct_i(cur), .overcurrent_level_setting_i(s.oc_level),
        .overcurrent_delay_setting_i(s.oc_delay), .zero_current_level_setting_i(s.zc_level),
        .zero_current_time_setting_i(s.zc_time), .overcurrent_retention_setting_i(s.oc_retention),
        .overcurrent_action_selection_i(s.oc_action_trip), .terminal_function_codes_i(codes),
        .overcurrent_detect_flag_o(f.oc_flag), .zero_current_flag_o(f.zc_flag),
        .overcurrent_trip_fault_o(fault), .term_o(term), .term_oe_o(term_oe));
    ext_equip #(.N(7)) u_ext_equip (.term_i(term), .term_oe_i(term_oe), .on_o(seen_on));
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    task automatic chk(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask
    // Latest edge a flag may appear after its qualifying time
    function automatic int lim(input int ticks);
        return (ticks + 1) * TK + 3;
    endfunction
    task automatic wait_lvl(input bit zc, input logic lvl, input int k, output int m);
        m = 0;
        while ((zc ? f.zc_flag : f.oc_flag) !== lvl && m < k) begin
            @(negedge clk_sys_i);
            m++;
        end
    endtask
    task automatic do_reset();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        running_i <= 1'b0;
        autotune_i <= 1'b0;
        cyc(2);
        rst_i <= 1'b0;
    endtask
    task automatic oc_run(input logic act, input bit hold, input bit fast);
        int d, r;
        d = fast ? 0 : 1 + $unsigned($random(seed)) % 4;
        r = hold ? 9999 : 1 + $unsigned($random(seed)) % 4;
        @(posedge clk_sys_i);
        s.oc_delay <= 14'(d);
        s.oc_retention <= 14'(r);
        s.oc_action_trip <= act;
        s.oc_level <= 8'h64 + 8'($unsigned($random(seed)) % 64);
        running_i <= 1'b1;
        cur <= 8'h14;
        cyc(2);
        cur <= 8'hdc;
        wait_lvl(0, 1'b1, lim(d), n);
        chk(f.oc_flag, 1'b1, "overcurrent flag");
        chk(n >= (d - 1) * TK && n < lim(d), 1'b1, "overcurrent delay");
        chk(fault, act, "trip at flag rise");
        @(negedge clk_sys_i);
        chk(seen_on[0], 1'b1, "positive terminal");
        chk(seen_on[1], 1'b0, "negative terminal");
        @(posedge clk_sys_i);
        cur <= 8'h14;
        s.oc_action_trip <= 1'b1;
        if (!hold) begin
            wait_lvl(0, 1'b0, lim(r), n);
            chk(f.oc_flag, 1'b0, "flag released");
            chk(n >= (r - 1) * TK && n < lim(r), 1'b1, "retention");
        end else begin
            cyc(lim(4));
            chk(f.oc_flag, 1'b1, "held flag");
            start_cmd_i <= 1'b1;
            cyc(1);
            start_cmd_i <= 1'b0;
            wait_lvl(0, 1'b0, 5, n);
            chk(f.oc_flag, act, "flag after start");
        end
        chk(fault, act, "fault state");
        $display("test overcurrent done");
    endtask
    task automatic zc_run(input logic [7:0] lvl, input bit tune);
        int t;
        t = 1 + $unsigned($random(seed)) % 5;
        @(posedge clk_sys_i);
        s.zc_level <= lvl;
        s.zc_time <= 14'(t);
        running_i <= !tune;
        autotune_i <= tune;
        cur <= 8'h50;
        cyc(2);
        cur <= 8'h02;
        wait_lvl(1, 1'b1, lim(t), n);
        chk(f.zc_flag, lvl != 8'h00, "zero current flag");
        if (lvl != 8'h00) begin
            chk(n >= (t - 1) * TK, 1'b1, "zero current time");
            @(negedge clk_sys_i);
            chk(seen_on[2] & !seen_on[3], 1'b1, "zero current terminals");
            @(posedge clk_sys_i);
            cur <= 8'h50;
            cyc(8 * TK);
            @(negedge clk_sys_i);
            chk(f.zc_flag, 1'b1, "minimum on time");
            wait_lvl(1, 1'b0, 3 * TK, n);
            chk(f.zc_flag, 1'b0, "zero current release");
        end
        $display("test zero current done");
    endtask
    task automatic report_and_stop();
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        s = {OC_LEVEL_RST, OC_DELAY_RST, ZC_LEVEL_RST, ZC_TIME_RST, OC_RETAIN_RST, 1'b0};
        cyc(12);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            oc_run(i[0], i > 1, i == 0);
            do_reset();
        end
        for (int i = 0; i < 3; i++) begin
            zc_run(i == 0 ? 8'h00 : 8'h05 + 8'($unsigned($random(seed)) % 16), i == 2);
            do_reset();
        end
        report_and_stop();
    end
endmodule
